// >>> src/spss_pkg.sv
package spss_pkg;

	// clock and time base
	localparam int CLK_MHZ = 250;
	localparam int TICK_US = 100;
	localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
	localparam int TRIM_US = 40;
	localparam int TRIM_CYCLES = CLK_MHZ * TRIM_US;
	localparam int TIMER_W = 18;

	// register offsets
	localparam logic [7:0] ADDR_STOP_SET = 8'h19;
	localparam logic [7:0] ADDR_PERIOD = 8'h1A;
	localparam logic [7:0] ADDR_TRIM = 8'h1B;
	localparam logic [7:0] ADDR_RETRY = 8'h1C;

	// reset values
	localparam logic [7:0] RST_STOP_SET = 8'h30;
	localparam logic [7:0] RST_PERIOD = 8'h0F;
	localparam logic RST_TRIM_SEL = 1'b1;
	localparam logic [7:0] RST_RETRY = 8'h02;

	// field positions
	localparam int PER_DIS_BIT = 7;
	localparam int TRIM_RSV_BIT = 7;
	localparam int TRIM_DONE_BIT = 6;
	localparam int TRIM_SEL_BIT = 1;
	localparam logic [3:0] RETRY_MIN_CODE = 4'h2;

	// ramp length per period code, in ticks of 0.1 ms
	localparam logic [TIMER_W-1:0] SS_TICKS [0:31] = '{
		18'h0, 18'h0, 18'h0, 18'h0, 18'h0, 18'h0, 18'h0, 18'h0,
		18'd165, 18'd239, 18'd314, 18'd404, 18'd539, 18'd703, 18'd942, 18'd1257,
		18'd1646, 18'd2394, 18'd3142, 18'd4039, 18'd5386, 18'd7031, 18'd9425, 18'd12566,
		18'd17281, 18'd25136, 18'd32991, 18'd42417, 18'd56556, 18'd73837, 18'd98973,
		18'd131964};

	// retry wait per code, in ticks of 0.1 ms
	localparam logic [TIMER_W-1:0] RETRY_TICKS [0:15] = '{
		18'h0, 18'h0, 18'd2990, 18'd4490, 18'd5980, 18'd7480, 18'd8980, 18'd10470,
		18'd11970, 18'd13460, 18'd14960, 18'd14960, 18'd14960, 18'd14960, 18'd14960,
		18'd14960};

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} spss_reg_req_t;

	typedef enum logic [2:0] {ST_OFF, ST_START, ST_RUN, ST_STOP, ST_RETRY} spss_state_t;

endpackage : spss_pkg

// >>> src/spss_timer.sv
`timescale 1ns/10ps
`default_nettype none
module spss_timer #(
	parameter int W = 18,
	parameter int PRESCALE = 25000
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic start,
	input wire logic [W-1:0] ticks,
	// status
	output logic busy,
	output logic expire
);

	localparam int PW = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
	localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE - 1);

	if (PRESCALE < 1 || W < 1)
		$error("spss_timer: bad prescale or width");

	logic [PW-1:0] pre;
	logic [W-1:0] cnt;
	logic [PW-1:0] next_pre;
	logic [W-1:0] next_cnt;
	logic next_busy;
	logic next_expire;

	// count prescaled ticks down to zero
	always_comb
	begin
		next_pre = pre;
		next_cnt = cnt;
		next_busy = busy;
		next_expire = 1'b0;
		if (start)
		begin
			next_pre = '0;
			next_cnt = ticks;
			next_busy = (ticks != '0);
			next_expire = (ticks == '0);
		end
		else if (busy)
		begin
			if (pre == PRE_LAST)
			begin
				next_pre = '0;
				next_cnt = cnt - W'(1);
				if (cnt == W'(1))
				begin
					next_busy = 1'b0;
					next_expire = 1'b1;
				end
			end
			else
				next_pre = pre + PW'(1);
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pre <= '0;
			cnt <= '0;
			busy <= 1'b0;
			expire <= 1'b0;
		end
		else
		begin
			pre <= next_pre;
			cnt <= next_cnt;
			busy <= next_busy;
			expire <= next_expire;
		end
	end

endmodule : spss_timer
`default_nettype wire

// >>> src/spss_sequencer.sv
// What this block does
// - reset loads the channel stop-set register with 0x30
// - on shutdown exit with control bit zero, stop-set channels stay stopped
// - stop-set bits 3..0 map to channels 4..1, one means member, default zero
// - ramp period on shutdown entry, exit or power-down change; bit 7 disables
// - outputs at 50% duty during ramp; period code upper bits zero means none
// - five-bit period code selects ramp length from a fixed table
// - ramp lengths are approximate only
// - writing zero to the trim register enables the factory trim
// - trim bit 6 is read-only done flag, zero until trim finishes
// - trim bit 1 written zero selects factory trim, resets to one
// - power stage error while starting, running or stopping resets the stage and halts all PWM outputs
// - after an error wait the retry period, then restart the stage
// - retry code low nibble selects 299 ms to 1496 ms
// - retry register takes only valid codes, once per reset
`timescale 1ns/10ps
`default_nettype none
module spss_sequencer
	import spss_pkg::*;
#(
	parameter int TICK_LEN = TICK_CYCLES,
	parameter int TRIM_LEN = TRIM_CYCLES
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// register access
	input wire spss_reg_req_t REG_REQ,
	output logic [7:0] REG_RDATA,
	// system control and pins
	input wire logic SHUTDOWN_ALL,
	input wire logic STOP_SET_BYPASS,
	input wire logic POWER_DOWN_INPUT_N,
	input wire logic BACKEND_ERR,
	// power stage
	output logic [3:0] CH_ACTIVE,
	output logic HALF_DUTY,
	output logic STAGE_RESET,
	output logic TRIM_FACTORY
);

	if (TICK_LEN < 1 || TRIM_LEN < 1 || TRIM_LEN >= (1 << TIMER_W))
		$error("spss_sequencer: bad tick or trim length");

	// input synchronisers
	logic [1:0] pdn_meta;
	logic [1:0] err_meta;
	logic pdn_sync;
	logic err_sync;

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			pdn_meta <= 2'h0;
			err_meta <= 2'h0;
		end
		else
		begin
			pdn_meta <= {pdn_meta[0], POWER_DOWN_INPUT_N};
			err_meta <= {err_meta[0], BACKEND_ERR};
		end
	end
	assign pdn_sync = pdn_meta[1];
	assign err_sync = err_meta[1];

	// registers
	logic [7:0] stop_set;
	logic [7:0] period;
	logic trim_sel;
	logic trim_done;
	logic [7:0] retry;
	logic retry_locked;
	logic [7:0] next_stop_set;
	logic [7:0] next_period;
	logic next_trim_sel;
	logic next_trim_done;
	logic [7:0] next_retry;
	logic next_retry_locked;
	logic [7:0] next_rdata;
	logic trim_start;
	logic trim_busy;
	logic trim_expire;
	logic wr_stop;
	logic wr_period;
	logic wr_trim;
	logic wr_retry;

	assign wr_stop = REG_REQ.wr && (REG_REQ.addr == ADDR_STOP_SET);
	assign wr_period = REG_REQ.wr && (REG_REQ.addr == ADDR_PERIOD);
	assign wr_trim = REG_REQ.wr && (REG_REQ.addr == ADDR_TRIM);
	assign wr_retry = REG_REQ.wr && (REG_REQ.addr == ADDR_RETRY);
	// trim ignores writes while running or finishing, so done set and clear never meet
	assign trim_start = wr_trim && !trim_busy && !trim_expire;

	always_comb
	begin
		next_stop_set = stop_set;
		next_period = period;
		next_trim_sel = trim_sel;
		next_trim_done = trim_done;
		next_retry = retry;
		next_retry_locked = retry_locked;
		next_rdata = REG_RDATA;
		if (wr_stop)
			next_stop_set = REG_REQ.wdata;
		if (wr_period)
			next_period = REG_REQ.wdata;
		if (trim_start)
		begin
			next_trim_sel = REG_REQ.wdata[TRIM_SEL_BIT];
			next_trim_done = 1'b0;
		end
		else if (trim_expire)
			next_trim_done = 1'b1;
		if (wr_retry && !retry_locked && REG_REQ.wdata[7:4] == 4'h0
			&& REG_REQ.wdata[3:0] >= RETRY_MIN_CODE)
		begin
			next_retry = REG_REQ.wdata;
			next_retry_locked = 1'b1;
		end
		if (REG_REQ.rd)
		begin
			case (REG_REQ.addr)
				ADDR_STOP_SET: next_rdata = stop_set;
				ADDR_PERIOD: next_rdata = period;
				ADDR_TRIM: next_rdata = {1'b1, trim_done, 4'h0, trim_sel, 1'b0};
				ADDR_RETRY: next_rdata = retry;
				default: next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			stop_set <= RST_STOP_SET;
			period <= RST_PERIOD;
			trim_sel <= RST_TRIM_SEL;
			trim_done <= 1'b0;
			retry <= RST_RETRY;
			retry_locked <= 1'b0;
			REG_RDATA <= 8'h00;
			TRIM_FACTORY <= 1'b0;
		end
		else
		begin
			stop_set <= next_stop_set;
			period <= next_period;
			trim_sel <= next_trim_sel;
			trim_done <= next_trim_done;
			retry <= next_retry;
			retry_locked <= next_retry_locked;
			REG_RDATA <= next_rdata;
			TRIM_FACTORY <= next_trim_done && !next_trim_sel;
		end
	end

	// oscillator trim counted in CLK cycles, without the tick prescaler
	spss_timer #(.W(TIMER_W), .PRESCALE(1)) u_trim (
		.clk(CLK),
		.rst(RST),
		.start(trim_start),
		.ticks(TIMER_W'(TRIM_LEN)),
		.busy(trim_busy),
		.expire(trim_expire)
	);

	// ramp and retry timers, lengths approximate by tick granularity
	logic ss_start;
	logic ss_expire;
	logic rt_start;
	logic rt_expire;
	logic [TIMER_W-1:0] ss_ticks;
	logic [TIMER_W-1:0] rt_ticks;
	logic ramp_en;

	assign ss_ticks = SS_TICKS[period[4:0]];
	assign rt_ticks = RETRY_TICKS[retry[3:0]];
	assign ramp_en = !period[PER_DIS_BIT] && (period[4:3] != 2'h0);

	spss_timer #(.W(TIMER_W), .PRESCALE(TICK_LEN)) u_ss (
		.clk(CLK),
		.rst(RST),
		.start(ss_start),
		.ticks(ss_ticks),
		.busy(),
		.expire(ss_expire)
	);

	spss_timer #(.W(TIMER_W), .PRESCALE(TICK_LEN)) u_rt (
		.clk(CLK),
		.rst(RST),
		.start(rt_start),
		.ticks(rt_ticks),
		.busy(),
		.expire(rt_expire)
	);

	// start and stop sequencing
	spss_state_t state;
	spss_state_t next_state;
	logic [3:0] run_mask;
	logic [3:0] next_run_mask;
	logic [3:0] stop_mask;
	logic desired;

	assign desired = !SHUTDOWN_ALL && pdn_sync;
	assign stop_mask = ~stop_set[3:0];

	always_comb
	begin
		next_state = state;
		next_run_mask = run_mask;
		ss_start = 1'b0;
		rt_start = 1'b0;
		case (state)
			ST_OFF:
				if (desired)
				begin
					next_run_mask = STOP_SET_BYPASS ? 4'hF : stop_mask;
					ss_start = ramp_en;
					next_state = ramp_en ? ST_START : ST_RUN;
				end
			ST_START:
				if (err_sync)
				begin
					rt_start = 1'b1;
					next_state = ST_RETRY;
				end
				else if (!desired)
				begin
					ss_start = 1'b1;
					next_state = ST_STOP;
				end
				else if (ss_expire)
					next_state = ST_RUN;
			ST_RUN:
				if (err_sync)
				begin
					rt_start = 1'b1;
					next_state = ST_RETRY;
				end
				else if (!desired)
				begin
					ss_start = ramp_en;
					next_state = ramp_en ? ST_STOP : ST_OFF;
				end
			ST_STOP:
				if (err_sync)
				begin
					rt_start = 1'b1;
					next_state = ST_RETRY;
				end
				else if (desired)
				begin
					ss_start = 1'b1;
					next_state = ST_START;
				end
				else if (ss_expire)
					next_state = ST_OFF;
			ST_RETRY:
				if (rt_expire)
					next_state = desired ? ST_RUN : ST_OFF;
			default:
				next_state = ST_OFF;
		endcase
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			state <= ST_OFF;
			run_mask <= 4'h0;
			CH_ACTIVE <= 4'h0;
			HALF_DUTY <= 1'b0;
			STAGE_RESET <= 1'b0;
		end
		else
		begin
			state <= next_state;
			run_mask <= next_run_mask;
			CH_ACTIVE <= (next_state inside {ST_START, ST_RUN, ST_STOP}) ? next_run_mask : 4'h0;
			HALF_DUTY <= (next_state inside {ST_START, ST_STOP});
			STAGE_RESET <= (next_state == ST_RETRY);
		end
	end

	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	a_reset_stop_set: assert property ($fell(RST) |-> stop_set == RST_STOP_SET)
		else $error("stop-set not at reset value");
	a_stop_mask_apply: assert property (
		(state == ST_OFF && desired && !STOP_SET_BYPASS) |=> CH_ACTIVE == $past(stop_mask))
		else $error("stop-set channels started");
	a_ramp_on_exit: assert property (
		(state == ST_OFF && desired && ramp_en) |=> (state == ST_START && HALF_DUTY))
		else $error("no ramp on shutdown exit");
	a_half_duty_ramp: assert property (
		HALF_DUTY == (state == ST_START || state == ST_STOP))
		else $error("half duty outside ramp");
	a_no_ramp_zero: assert property (
		(state == ST_OFF && desired && !ramp_en) |=> (state == ST_RUN && !HALF_DUTY))
		else $error("ramp taken with zero period");
	a_err_halt: assert property (
		(state == ST_RUN && err_sync) |=> (STAGE_RESET && CH_ACTIVE == 4'h0))
		else $error("error did not halt stage");
	a_retry_hold: assert property ($rose(STAGE_RESET) |-> STAGE_RESET [*8])
		else $error("retry wait too short");
	a_retry_lock: assert property (
		(retry_locked && wr_retry) |=> $stable(retry))
		else $error("retry register rewritten");
	a_trim_clear: assert property (trim_start |=> (!trim_done && trim_sel == $past(REG_REQ.wdata[1])))
		else $error("trim write not applied");

	c_start_run: cover property (state == ST_START ##1 state == ST_RUN);
	c_retry_restart: cover property (state == ST_RETRY ##1 state == ST_RUN);
	c_trim_done: cover property ($rose(trim_done));
	c_ramp_reverse: cover property (state == ST_START ##1 state == ST_STOP);

endmodule : spss_sequencer
`default_nettype wire

// >>> dv/spss_host.sv
`timescale 1ns/10ps
`default_nettype none
module spss_host
	import spss_pkg::*;
(
	// register port
	input wire logic clk,
	input wire logic [7:0] rdata,
	output var spss_reg_req_t req
);
	initial req = '0;

	// one-cycle write strobe, taken at the next rising edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge clk);
		req = '0;
	endtask : wr

	// read data holds until the next read, sampled a cycle later
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge clk);
		req = '0;
		@(negedge clk);
		d = rdata;
	endtask : rd
endmodule : spss_host
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	import spss_pkg::*;
	localparam int TK = 4;
	logic clk, rst, shut, bypass, pdn_n, berr, half, sreset, tfac;
	logic [3:0] ch;
	logic [7:0] rdata;
	spss_reg_req_t req;
	int err_total, samples_checked;

	spss_sequencer #(.TICK_LEN(TK), .TRIM_LEN(20)) dut (.CLK(clk), .RST(rst), .REG_REQ(req),
		.REG_RDATA(rdata), .SHUTDOWN_ALL(shut), .STOP_SET_BYPASS(bypass),
		.POWER_DOWN_INPUT_N(pdn_n), .BACKEND_ERR(berr), .CH_ACTIVE(ch), .HALF_DUTY(half),
		.STAGE_RESET(sreset), .TRIM_FACTORY(tfac));
	spss_host host (.clk(clk), .rdata(rdata), .req(req));

	task automatic results;
		if (err_total == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : results

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		host.rd(a, v);
		chk(v, exp);
	endtask : rchk

	task automatic wait_n(input int n);
		repeat (n) @(negedge clk);
	endtask : wait_n

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial
	begin
		#200000;
		err_total++;
		results;
	end

	initial
	begin
		rst = 1'b1;
		shut = 1'b1;
		bypass = 1'b0;
		pdn_n = 1'b1;
		berr = 1'b0;
		err_total = 0;
		samples_checked = 0;
		wait_n(16);
		rst = 1'b0;
		rchk(ADDR_STOP_SET, 8'h30); // stop-set default
		rchk(ADDR_PERIOD, 8'h0F); // period default
		rchk(ADDR_TRIM, 8'h82); // trim default
		rchk(ADDR_RETRY, 8'h02); // retry default
		rchk(8'h1D, 8'h00); // unmapped
		host.wr(ADDR_TRIM, 8'h00); // trim after reset
		rchk(ADDR_TRIM, 8'h80); // not done yet
		host.wr(ADDR_TRIM, 8'h02); // ignored while trimming
		wait_n(30);
		rchk(ADDR_TRIM, 8'hC0); // done flag
		chk({7'h00, tfac}, 8'h01); // factory trim on
		host.wr(ADDR_RETRY, 8'h01); // reserved code
		rchk(ADDR_RETRY, 8'h02); // refused
		host.wr(ADDR_RETRY, 8'h13); // reserved high bits
		rchk(ADDR_RETRY, 8'h02); // refused
		host.wr(ADDR_RETRY, 8'h03); // single valid write
		rchk(ADDR_RETRY, 8'h03); // taken
		host.wr(ADDR_RETRY, 8'h05); // second write
		rchk(ADDR_RETRY, 8'h03); // locked
		host.wr(ADDR_STOP_SET, 8'h3A); // parallel bridged
		host.wr(ADDR_PERIOD, 8'h08); // shortest ramp
		shut = 1'b0;
		wait_n(2);
		chk({4'h0, ch}, 8'h05); // channels 2 and 4 held
		chk({7'h00, half}, 8'h01); // start ramp
		wait_n(165 * TK - 20);
		chk({7'h00, half}, 8'h01); // ramp length
		wait_n(40);
		chk({7'h00, half}, 8'h00); // ramp over
		berr = 1'b1;
		wait_n(1);
		berr = 1'b0;
		wait_n(5);
		chk({7'h00, sreset}, 8'h01); // stage reset
		chk({4'h0, ch}, 8'h00); // outputs halted
		wait_n(4490 * TK - 20);
		chk({7'h00, sreset}, 8'h01); // still waiting
		wait_n(40);
		chk({7'h00, sreset}, 8'h00); // restart
		chk({4'h0, ch}, 8'h05); // same channels back
		shut = 1'b1;
		wait_n(2);
		chk({7'h00, half}, 8'h01); // stop ramp
		wait_n(165 * TK + 20);
		chk({4'h0, ch}, 8'h00); // stopped after ramp
		bypass = 1'b1;
		host.wr(ADDR_PERIOD, 8'h88); // timer disabled
		shut = 1'b0;
		wait_n(2);
		chk({4'h0, ch}, 8'h0F); // bypass starts all
		chk({7'h00, half}, 8'h00); // no ramp
		shut = 1'b1;
		wait_n(2);
		chk({4'h0, ch}, 8'h00); // stop without ramp
		host.wr(ADDR_PERIOD, 8'h07); // code with zero upper bits
		shut = 1'b0;
		wait_n(2);
		chk({7'h00, half}, 8'h00); // no ramp period
		chk({4'h0, ch}, 8'h0F); // running
		pdn_n = 1'b0;
		wait_n(4);
		chk({4'h0, ch}, 8'h00); // power down stops
		shut = 1'b1;
		pdn_n = 1'b1;
		host.wr(ADDR_PERIOD, 8'h08); // ramp on again
		shut = 1'b0;
		wait_n(100);
		shut = 1'b1;
		wait_n(2);
		chk({3'h0, half, ch}, 8'h1F); // reversal keeps ramp
		wait_n(165 * TK - 20);
		chk({3'h0, half, ch}, 8'h1F); // stop ramp restarted
		wait_n(40);
		chk({3'h0, half, ch}, 8'h00); // stopped after ramp
		results;
	end
endmodule : tb
`default_nettype wire
